// ==== rtl/crcstat_pkg.sv ====
package crcstat_pkg;

   // register byte offsets on the wishbone bus
   localparam logic [7:0] IFC_CRC_OFS  = 8'h00;
   localparam logic [7:0] ARR_CRC_OFS  = 8'h04;
   localparam logic [7:0] ECC_STAT_OFS = 8'h08;
   localparam logic [7:0] CTRL_OFS     = 8'h0C;
   localparam logic [7:0] IRQ_STAT_OFS = 8'h10;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h14;

   // reset values
   localparam logic [31:0] IFC_CRC_RST  = 32'hFFFFFFFF;
   localparam logic [31:0] ARR_CRC_RST  = 32'h00000000;
   localparam logic [7:0]  ECC_STAT_RST = 8'h00;
   localparam logic [7:0]  CTRL_RST     = 8'h00;

   // ecc status field positions
   localparam int DBL_BIT = 4;
   localparam int SGL_BIT = 3;

   // control field positions
   localparam int CTRL_DIS_BIT = 0;
   localparam int CTRL_CLR_BIT = 1;

   // ecc unit geometry: 16 bytes, 128 bits
   localparam int ECC_UNIT_BYTES = 16;
   localparam int ECC_UNIT_BITS  = 128;
   localparam int ECC_UNIT_SHIFT = $clog2(ECC_UNIT_BYTES);

   // interrupt event positions
   localparam int EV_IFC = 0;
   localparam int EV_ARR = 1;
   localparam int EV_SGL = 2;
   localparam int EV_DBL = 3;
   localparam int EV_NUM = 4;

endpackage

// ==== rtl/ecc_flag_keeper.sv ====
module ecc_flag_keeper #(
   parameter int AW = 32
) (
   input  wire logic                                   clk_i,
   input  wire logic                                   rst_i,
   input  wire logic                                   read_i,
   input  wire logic [AW-1:0]                          addr_i,
   input  wire logic                                   single_i,
   input  wire logic                                   double_i,
   input  wire logic                                   clear_i,
   output logic                                        single_o,
   output logic                                        double_o,
   output logic [AW-crcstat_pkg::ECC_UNIT_SHIFT-1:0]   unit_o
);

   // a read that reports an error in the clear cycle still sets its flag
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         double_o <= 1'b0;
      end else if (read_i && double_i) begin
         double_o <= 1'b1;
      end else if (clear_i) begin
         double_o <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         single_o <= 1'b0;
      end else if (read_i && single_i) begin
         single_o <= 1'b1;
      end else if (clear_i) begin
         single_o <= 1'b0;
      end
   end

   // unit holding the byte of the most recent array read
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         unit_o <= '0;
      end else if (read_i) begin
         unit_o <= addr_i[AW-1:crcstat_pkg::ECC_UNIT_SHIFT];
      end
   end

endmodule

// ==== rtl/event_irq_bank.sv ====
module event_irq_bank #(
   parameter int N = 4
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic [N-1:0] event_i,
   input  wire logic [N-1:0] clear_i,
   input  wire logic         mask_we_i,
   input  wire logic [N-1:0] mask_i,
   output logic [N-1:0]      status_o,
   output logic [N-1:0]      mask_o,
   output logic              irq_o
);

   // sticky bits, set wins over a write-one clear
   for (genvar i = 0; i < N; i++) begin : g_bit
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            status_o[i] <= 1'b0;
         end else if (event_i[i]) begin
            status_o[i] <= 1'b1;
         end else if (clear_i[i]) begin
            status_o[i] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mask_o <= '0;
      end else if (mask_we_i) begin
         mask_o <= mask_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(status_o & mask_o);
      end
   end

endmodule

// ==== rtl/ecc_crc_status_regs.sv ====
// What this block does
// - keep 32-bit interface CRC result, read-only
// - interface CRC resets to all ones, ignores writes
// - keep 32-bit array range CRC, reset zero
// - ECC status covers one 16-byte unit
// - status tracks unit of latest read byte
// - bit 4 set on 2-bit error
// - double flag evaluated each read, sticky
// - clear transaction alone resets double flag; here a CTRL bit 1 write strobe also clears it
// - bit 3 set on corrected 1-bit error
// - single flag evaluated each read, sticky
// - clear transaction alone resets single flag; here a CTRL bit 1 write strobe also clears it
// - reserved status bits read zero
// - interface CRC active while disable bit zero
//
// Decided for this implementation: the register offsets and the Wishbone slave port.
module ecc_crc_status_regs #(
   parameter int AW = 32
) (
   input  wire logic                                   REF_CLK_I,
   input  wire logic                                   SYS_RST_I,
   input  wire logic                                   WB_CYC_I,
   input  wire logic                                   WB_STB_I,
   input  wire logic                                   WB_WE_I,
   input  wire logic [7:0]                             WB_ADR_I,
   input  wire logic [3:0]                             WB_SEL_I,
   input  wire logic [31:0]                            WB_DAT_I,
   output logic      [31:0]                            WB_DAT_O,
   output logic                                        WB_ACK_O,
   input  wire logic                                   IFC_CRC_VALID_I,
   input  wire logic [31:0]                            IFC_CRC_I,
   input  wire logic                                   ARR_CRC_VALID_I,
   input  wire logic [31:0]                            ARR_CRC_I,
   input  wire logic                                   ARR_READ_I,
   input  wire logic [AW-1:0]                          ARR_READ_ADDR_I,
   input  wire logic                                   ECC_SINGLE_I,
   input  wire logic                                   ECC_DOUBLE_I,
   input  wire logic                                   ECC_CLEAR_I,
   output logic                                        IFC_CRC_EN_O,
   output logic [AW-crcstat_pkg::ECC_UNIT_SHIFT-1:0]   ECC_UNIT_ADDR_O,
   output logic                                        IRQ_O
);

   localparam int EN = crcstat_pkg::EV_NUM;
   localparam int UW = AW - crcstat_pkg::ECC_UNIT_SHIFT;

   logic [31:0]   interface_crc_check_value;
   logic [31:0]   array_crc_check_value;
   logic [7:0]    ecc_error_status;
   logic [7:0]    config_register_four;
   logic          interface_crc_disable_bit;
   logic          single_error_flag;
   logic          double_error_flag;
   logic          clear_ecc_status_transaction;
   logic          sw_clear_reg;
   logic          ack_reg;
   logic [31:0]   rd_data_next;
   logic          bus_req;
   logic          bus_wr;
   logic          ifc_store;
   logic          arr_store;
   logic [EN-1:0] ev_vec;
   logic [EN-1:0] ev_clear;
   logic          mask_we;
   logic [EN-1:0] irq_status;
   logic [EN-1:0] irq_mask;
   logic          irq_flop;
   logic [UW-1:0] unit_flop;

   // --------------------------------------------------------------
   // wishbone classic slave: one wait state, ack for a single cycle
   // --------------------------------------------------------------
   assign bus_req = WB_CYC_I && WB_STB_I && !ack_reg;
   assign bus_wr  = bus_req && WB_WE_I;

   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= bus_req;
      end
   end

   always_comb begin
      rd_data_next = 32'h00000000;
      case (WB_ADR_I)
         crcstat_pkg::IFC_CRC_OFS: begin
            rd_data_next = interface_crc_check_value;
         end
         crcstat_pkg::ARR_CRC_OFS: begin
            rd_data_next = array_crc_check_value;
         end
         crcstat_pkg::ECC_STAT_OFS: begin
            rd_data_next[7:0] = ecc_error_status;
         end
         crcstat_pkg::CTRL_OFS: begin
            rd_data_next[7:0] = config_register_four;
         end
         crcstat_pkg::IRQ_STAT_OFS: begin
            rd_data_next[EN-1:0] = irq_status;
         end
         crcstat_pkg::IRQ_MASK_OFS: begin
            rd_data_next[EN-1:0] = irq_mask;
         end
         default: begin
            rd_data_next = 32'h00000000;
         end
      endcase
   end

   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         WB_DAT_O <= 32'h00000000;
      end else if (bus_req && !WB_WE_I) begin
         WB_DAT_O <= rd_data_next;
      end
   end

   assign WB_ACK_O = ack_reg;

   // --------------------------------------------------------------
   // control: crc disable level and self-clearing ecc clear strobe
   // --------------------------------------------------------------
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         interface_crc_disable_bit <= crcstat_pkg::CTRL_RST[crcstat_pkg::CTRL_DIS_BIT];
      end else if (bus_wr && WB_SEL_I[0] && WB_ADR_I == crcstat_pkg::CTRL_OFS) begin
         interface_crc_disable_bit <= WB_DAT_I[crcstat_pkg::CTRL_DIS_BIT];
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         sw_clear_reg <= 1'b0;
      end else begin
         sw_clear_reg <= bus_wr && WB_SEL_I[0] && WB_ADR_I == crcstat_pkg::CTRL_OFS
                         && WB_DAT_I[crcstat_pkg::CTRL_CLR_BIT];
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         IFC_CRC_EN_O <= !crcstat_pkg::CTRL_RST[crcstat_pkg::CTRL_DIS_BIT];
      end else begin
         IFC_CRC_EN_O <= !interface_crc_disable_bit;
      end
   end

   always_comb begin
      config_register_four = crcstat_pkg::CTRL_RST;
      config_register_four[crcstat_pkg::CTRL_DIS_BIT] = interface_crc_disable_bit;
   end

   // host transaction or software strobe, both flags at once
   assign clear_ecc_status_transaction = ECC_CLEAR_I || sw_clear_reg;

   // --------------------------------------------------------------
   // crc result registers, bus writes never reach them
   // --------------------------------------------------------------
   assign ifc_store = IFC_CRC_VALID_I && !interface_crc_disable_bit;
   assign arr_store = ARR_CRC_VALID_I;

   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         interface_crc_check_value <= crcstat_pkg::IFC_CRC_RST;
      end else if (ifc_store) begin
         interface_crc_check_value <= IFC_CRC_I;
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         array_crc_check_value <= crcstat_pkg::ARR_CRC_RST;
      end else if (arr_store) begin
         array_crc_check_value <= ARR_CRC_I;
      end
   end

   // --------------------------------------------------------------
   // ecc flags for the 16-byte unit of the latest array read
   // --------------------------------------------------------------
   ecc_flag_keeper #(
      .AW (AW)
   ) u_flags (
      .clk_i    (REF_CLK_I),
      .rst_i    (SYS_RST_I),
      .read_i   (ARR_READ_I),
      .addr_i   (ARR_READ_ADDR_I),
      .single_i (ECC_SINGLE_I),
      .double_i (ECC_DOUBLE_I),
      .clear_i  (clear_ecc_status_transaction),
      .single_o (single_error_flag),
      .double_o (double_error_flag),
      .unit_o   (unit_flop)
   );

   assign ECC_UNIT_ADDR_O = unit_flop;

   always_comb begin
      ecc_error_status = crcstat_pkg::ECC_STAT_RST;
      ecc_error_status[crcstat_pkg::DBL_BIT] = double_error_flag;
      ecc_error_status[crcstat_pkg::SGL_BIT] = single_error_flag;
   end

   // --------------------------------------------------------------
   // interrupts: sticky events, write one to clear, mask
   // --------------------------------------------------------------
   always_comb begin
      ev_vec = '0;
      ev_vec[crcstat_pkg::EV_IFC] = ifc_store;
      ev_vec[crcstat_pkg::EV_ARR] = arr_store;
      ev_vec[crcstat_pkg::EV_SGL] = ARR_READ_I && ECC_SINGLE_I;
      ev_vec[crcstat_pkg::EV_DBL] = ARR_READ_I && ECC_DOUBLE_I;
   end

   assign ev_clear = (bus_wr && WB_SEL_I[0] && WB_ADR_I == crcstat_pkg::IRQ_STAT_OFS)
                     ? WB_DAT_I[EN-1:0] : '0;
   assign mask_we  = bus_wr && WB_SEL_I[0] && WB_ADR_I == crcstat_pkg::IRQ_MASK_OFS;

   event_irq_bank #(
      .N (EN)
   ) u_irq (
      .clk_i     (REF_CLK_I),
      .rst_i     (SYS_RST_I),
      .event_i   (ev_vec),
      .clear_i   (ev_clear),
      .mask_we_i (mask_we),
      .mask_i    (WB_DAT_I[EN-1:0]),
      .status_o  (irq_status),
      .mask_o    (irq_mask),
      .irq_o     (irq_flop)
   );

   assign IRQ_O = irq_flop;

   // --------------------------------------------------------------
   // checks
   // --------------------------------------------------------------
   AST_IFC_RESET_ONES: assert property (
      @(posedge REF_CLK_I) $fell(SYS_RST_I)
         |-> interface_crc_check_value == crcstat_pkg::IFC_CRC_RST
             && array_crc_check_value == crcstat_pkg::ARR_CRC_RST)
      else $error("crc registers wrong after reset");

   AST_IFC_STORE: assert property (
      @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      IFC_CRC_VALID_I && !interface_crc_disable_bit
         |=> interface_crc_check_value == $past(IFC_CRC_I))
      else $error("interface crc result not stored");

   AST_IFC_DISABLED_HOLD: assert property (
      @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      interface_crc_disable_bit |=> $stable(interface_crc_check_value) && !IFC_CRC_EN_O)
      else $error("interface crc changed while disabled");

   AST_IFC_WRITE_IGNORED: assert property (
      @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      bus_wr && WB_ADR_I == crcstat_pkg::IFC_CRC_OFS && !IFC_CRC_VALID_I
         |=> $stable(interface_crc_check_value))
      else $error("bus write reached interface crc");

   AST_ARR_STORE: assert property (
      @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      ARR_CRC_VALID_I |=> array_crc_check_value == $past(ARR_CRC_I))
      else $error("array crc result not stored");

   AST_DBL_SET: assert property (
      @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      ARR_READ_I && ECC_DOUBLE_I |=> double_error_flag ##1 irq_status[crcstat_pkg::EV_DBL])
      else $error("double error flag not set");

   AST_DBL_STICKY: assert property (
      @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      double_error_flag && !clear_ecc_status_transaction |=> double_error_flag)
      else $error("double error flag dropped without clear");

   AST_SGL_SET: assert property (
      @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      ARR_READ_I && ECC_SINGLE_I |=> single_error_flag)
      else $error("single error flag not set");

   AST_SGL_STICKY: assert property (
      @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      single_error_flag && !clear_ecc_status_transaction |=> single_error_flag)
      else $error("single error flag dropped without clear");

   AST_CLEAR_BOTH: assert property (
      @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      clear_ecc_status_transaction && !ARR_READ_I && !ARR_CRC_VALID_I && !IFC_CRC_VALID_I
         |=> !single_error_flag && !double_error_flag
             && $stable(array_crc_check_value) && $stable(interface_crc_check_value))
      else $error("ecc clear wrong");

   AST_RSVD_ZERO: assert property (
      @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      bus_req && !WB_WE_I && WB_ADR_I == crcstat_pkg::ECC_STAT_OFS
         |=> WB_ACK_O && WB_DAT_O[7:5] == 3'h0 && WB_DAT_O[2:0] == 3'h0
             && WB_DAT_O[4] == $past(double_error_flag))
      else $error("ecc status read image wrong");

   AST_UNIT_TRACK: assert property (
      @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      ARR_READ_I |=> ECC_UNIT_ADDR_O == $past(ARR_READ_ADDR_I[AW-1:crcstat_pkg::ECC_UNIT_SHIFT]))
      else $error("ecc unit address not tracked");

   AST_ACK_ONE: assert property (
      @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      bus_req |=> WB_ACK_O ##1 !WB_ACK_O)
      else $error("ack not a single cycle");

   AST_IRQ_LEVEL: assert property (
      @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      |(irq_status & irq_mask) |=> IRQ_O)
      else $error("interrupt not raised");

   AST_ARR_WRITE_IGNORED: assert property (
      @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      bus_wr && WB_ADR_I == crcstat_pkg::ARR_CRC_OFS && !ARR_CRC_VALID_I
         |=> $stable(array_crc_check_value))
      else $error("bus write reached array crc");

   AST_IFC_KEEP: assert property (
      @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      !IFC_CRC_VALID_I |=> $stable(interface_crc_check_value))
      else $error("interface crc changed without a result");

   AST_IFC_EN_ON: assert property (
      @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      !interface_crc_disable_bit |=> IFC_CRC_EN_O)
      else $error("interface crc not active while enabled");

   AST_DBL_ONLY_ON_ERROR: assert property (
      @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      !double_error_flag && !(ARR_READ_I && ECC_DOUBLE_I) |=> !double_error_flag)
      else $error("double error flag set without an error");

   AST_SGL_ONLY_ON_ERROR: assert property (
      @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      !single_error_flag && !(ARR_READ_I && ECC_SINGLE_I) |=> !single_error_flag)
      else $error("single error flag set without an error");

   AST_IRQ_QUIET: assert property (
      @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      !(|(irq_status & irq_mask)) |=> !IRQ_O)
      else $error("interrupt raised without an unmasked event");

endmodule

// ==== tb/host_link_model.sv ====
module host_link_model (
   input  wire logic        clk_i,
   output logic             ifc_valid_o,
   output logic [31:0]      ifc_crc_o,
   output logic             arr_valid_o,
   output logic [31:0]      arr_crc_o,
   output logic             read_o,
   output logic [31:0]      addr_o,
   output logic             single_o,
   output logic             double_o,
   output logic             clear_o
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      {ifc_valid_o, arr_valid_o, read_o, single_o, double_o, clear_o} = 6'h00;
      ifc_crc_o = 32'h00000000;
      arr_crc_o = 32'h00000000;
      addr_o    = 32'h00000000;
   end

   // data lines show the inverse once the strobe is gone
   task automatic store_crc(input logic arr, input logic [31:0] val);
      @(posedge clk_i);
      if (arr) begin
         arr_valid_o <= 1'b1;
         arr_crc_o   <= val;
      end else begin
         ifc_valid_o <= 1'b1;
         ifc_crc_o   <= val;
      end
      @(posedge clk_i);
      {ifc_valid_o, arr_valid_o} <= 2'h0;
      ifc_crc_o <= ~val;
      arr_crc_o <= ~val;
   endtask

   task automatic array_read(input logic [31:0] adr, input logic sgl, input logic dbl);
      @(posedge clk_i);
      read_o   <= 1'b1;
      addr_o   <= adr;
      single_o <= sgl;
      double_o <= dbl;
      @(posedge clk_i);
      read_o   <= 1'b0;
      addr_o   <= ~adr;
      single_o <= ~sgl;
      double_o <= ~dbl;
   endtask

   // host clear transaction, one cycle long
   task automatic clear_ecc();
      @(posedge clk_i);
      clear_o <= 1'b1;
      @(posedge clk_i);
      clear_o <= 1'b0;
   endtask

   // the host drops the single flag whenever the double flag is set
   function automatic logic [7:0] ecc_view(input logic [7:0] st);
      return st[4] ? (st & 8'hF7) : st;
   endfunction
endmodule

// ==== tb/ecc_crc_status_regs_tb.sv ====
module ecc_crc_status_regs_tb;
   timeunit 1ns;
   timeprecision 100ps;

   logic        ref_clk;
   logic        sys_rst;
   logic        wb_cyc;
   logic        wb_stb;
   logic        wb_we;
   logic [7:0]  wb_adr;
   logic [3:0]  wb_sel;
   logic [31:0] wb_dat_w;
   logic [31:0] wb_dat_r;
   logic        wb_ack;
   logic        ifc_v;
   logic [31:0] ifc_crc;
   logic        arr_v;
   logic [31:0] arr_crc;
   logic        rd_str;
   logic [31:0] rd_adr;
   logic        e_sgl;
   logic        e_dbl;
   logic        e_clr;
   logic        ifc_en;
   logic [27:0] unit;
   logic        irq;
   int          error_cnt = 0;
   int          checks_done = 0;

   ecc_crc_status_regs #(.AW(32)) DUT (
      .REF_CLK_I(ref_clk), .SYS_RST_I(sys_rst), .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb),
      .WB_WE_I(wb_we), .WB_ADR_I(wb_adr), .WB_SEL_I(wb_sel), .WB_DAT_I(wb_dat_w),
      .WB_DAT_O(wb_dat_r), .WB_ACK_O(wb_ack), .IFC_CRC_VALID_I(ifc_v), .IFC_CRC_I(ifc_crc),
      .ARR_CRC_VALID_I(arr_v), .ARR_CRC_I(arr_crc), .ARR_READ_I(rd_str),
      .ARR_READ_ADDR_I(rd_adr), .ECC_SINGLE_I(e_sgl), .ECC_DOUBLE_I(e_dbl),
      .ECC_CLEAR_I(e_clr), .IFC_CRC_EN_O(ifc_en), .ECC_UNIT_ADDR_O(unit), .IRQ_O(irq));

   host_link_model model (
      .clk_i(ref_clk), .ifc_valid_o(ifc_v), .ifc_crc_o(ifc_crc), .arr_valid_o(arr_v),
      .arr_crc_o(arr_crc), .read_o(rd_str), .addr_o(rd_adr), .single_o(e_sgl),
      .double_o(e_dbl), .clear_o(e_clr));

   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                          output logic [31:0] rd);
      int n;
      @(posedge ref_clk);
      wb_cyc   <= 1'b1;
      wb_stb   <= 1'b1;
      wb_we    <= we;
      wb_adr   <= adr;
      wb_sel   <= we ? 4'h1 : 4'hF;
      wb_dat_w <= wd;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (wb_ack !== 1'b1 && n < 50);
      chk("wb_ack", 32'h00000001, {31'h0, wb_ack});
      rd = wb_dat_r;
      wb_cyc   <= 1'b0;
      wb_stb   <= 1'b0;
      wb_we    <= 1'b0;
      wb_dat_w <= ~wd;
   endtask

   task automatic wr(input logic [7:0] adr, input logic [31:0] d);
      logic [31:0] dummy;
      wb_xfer(1'b1, adr, d, dummy);
   endtask

   task automatic rd_chk(input string name, input logic [7:0] adr, input logic [31:0] exp);
      logic [31:0] d;
      wb_xfer(1'b0, adr, 32'h00000000, d);
      chk(name, exp, d);
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic t_reset();
      rd_chk("ifc_crc", crcstat_pkg::IFC_CRC_OFS, 32'hFFFFFFFF);
      rd_chk("arr_crc", crcstat_pkg::ARR_CRC_OFS, 32'h00000000);
      rd_chk("ecc_stat", crcstat_pkg::ECC_STAT_OFS, 32'h00000000);
      chk("ifc_en", 32'h00000001, {31'h0, ifc_en});
      $display("test reset done");
   endtask

   task automatic t_ro_write();
      wr(crcstat_pkg::IFC_CRC_OFS, 32'h12345678);
      wr(crcstat_pkg::ARR_CRC_OFS, 32'h12345678);
      wr(crcstat_pkg::ECC_STAT_OFS, 32'h000000FF);
      wr(8'h20, 32'h12345678);
      rd_chk("ifc_crc", crcstat_pkg::IFC_CRC_OFS, 32'hFFFFFFFF);
      rd_chk("arr_crc", crcstat_pkg::ARR_CRC_OFS, 32'h00000000);
      rd_chk("ecc_stat", crcstat_pkg::ECC_STAT_OFS, 32'h00000000);
      rd_chk("unmapped", 8'h20, 32'h00000000);
      $display("test read_only done");
   endtask

   task automatic t_crc();
      model.store_crc(1'b0, 32'hA5A5C3C3);
      model.store_crc(1'b1, 32'h3C3C5A5A);
      rd_chk("ifc_crc", crcstat_pkg::IFC_CRC_OFS, 32'hA5A5C3C3);
      rd_chk("arr_crc", crcstat_pkg::ARR_CRC_OFS, 32'h3C3C5A5A);
      rd_chk("irq_stat", crcstat_pkg::IRQ_STAT_OFS, 32'h00000003);
      wr(crcstat_pkg::IRQ_STAT_OFS, 32'h00000003);
      wr(crcstat_pkg::CTRL_OFS, 32'h00000001);
      wait_cyc(2);
      chk("ifc_en", 32'h00000000, {31'h0, ifc_en});
      model.store_crc(1'b0, 32'h0F0F0F0F);
      rd_chk("ifc_crc", crcstat_pkg::IFC_CRC_OFS, 32'hA5A5C3C3);
      rd_chk("irq_stat", crcstat_pkg::IRQ_STAT_OFS, 32'h00000000);
      wr(crcstat_pkg::CTRL_OFS, 32'h00000000);
      wait_cyc(2);
      chk("ifc_en", 32'h00000001, {31'h0, ifc_en});
      $display("test crc done");
   endtask

   task automatic t_ecc();
      logic [31:0] st;
      model.array_read(32'h00001234, 1'b1, 1'b0);
      rd_chk("ecc_stat", crcstat_pkg::ECC_STAT_OFS, 32'h00000008);
      chk("unit", 32'h00001234 >> crcstat_pkg::ECC_UNIT_SHIFT, {4'h0, unit});
      model.array_read(32'h0000005F, 1'b0, 1'b0);
      rd_chk("ecc_stat", crcstat_pkg::ECC_STAT_OFS, 32'h00000008);
      chk("unit", 32'h00000005, {4'h0, unit});
      model.array_read(32'h00000060, 1'b0, 1'b1);
      model.array_read(32'h00000070, 1'b0, 1'b0);
      wb_xfer(1'b0, crcstat_pkg::ECC_STAT_OFS, 32'h00000000, st);
      chk("ecc_stat", 32'h00000018, st);
      chk("host_view", 32'h00000010, {24'h0, model.ecc_view(st[7:0])});
      model.clear_ecc();
      rd_chk("ecc_stat", crcstat_pkg::ECC_STAT_OFS, 32'h00000000);
      rd_chk("ifc_crc", crcstat_pkg::IFC_CRC_OFS, 32'hA5A5C3C3);
      rd_chk("arr_crc", crcstat_pkg::ARR_CRC_OFS, 32'h3C3C5A5A);
      model.array_read(32'h00000080, 1'b1, 1'b0);
      wr(crcstat_pkg::CTRL_OFS, 32'h00000002);
      wait_cyc(2);
      rd_chk("ecc_stat", crcstat_pkg::ECC_STAT_OFS, 32'h00000000);
      rd_chk("ctrl", crcstat_pkg::CTRL_OFS, 32'h00000000);
      // error read in the clear cycle: the set wins
      fork
         model.clear_ecc();
         model.array_read(32'h00000090, 1'b0, 1'b1);
      join
      rd_chk("ecc_stat", crcstat_pkg::ECC_STAT_OFS, 32'h00000010);
      $display("test ecc done");
   endtask

   task automatic t_irq();
      wr(crcstat_pkg::IRQ_MASK_OFS, 32'h00000000);
      wr(crcstat_pkg::IRQ_STAT_OFS, 32'h0000000F);
      wait_cyc(3);
      rd_chk("irq_stat", crcstat_pkg::IRQ_STAT_OFS, 32'h00000000);
      model.array_read(32'h00000100, 1'b1, 1'b0);
      wait_cyc(4);
      rd_chk("irq_stat", crcstat_pkg::IRQ_STAT_OFS, 32'h00000004);
      chk("irq", 32'h00000000, {31'h0, irq});
      wr(crcstat_pkg::IRQ_MASK_OFS, 32'h00000004);
      wait_cyc(3);
      chk("irq", 32'h00000001, {31'h0, irq});
      rd_chk("irq_mask", crcstat_pkg::IRQ_MASK_OFS, 32'h00000004);
      wr(crcstat_pkg::IRQ_STAT_OFS, 32'h00000004);
      wait_cyc(3);
      chk("irq", 32'h00000000, {31'h0, irq});
      $display("test irq done");
   endtask

   initial begin
      sys_rst  = 1'b1;
      wb_cyc   = 1'b0;
      wb_stb   = 1'b0;
      wb_we    = 1'b0;
      wb_adr   = 8'h00;
      wb_sel   = 4'h0;
      wb_dat_w = 32'h00000000;
      wait_cyc(10);
      sys_rst <= 1'b0;
      t_reset();
      t_ro_write();
      t_crc();
      t_ecc();
      t_irq();
      finish_test();
   end

   initial begin
      #200000;
      error_cnt++;
      $display("CHECK FAILED watchdog expected done seen timeout");
      finish_test();
   end
endmodule
